// ==== pkg/wttlb_pkg.sv ====
package wttlb_pkg;

  // ------------------------------------------------------------------
  // Structure
  // ------------------------------------------------------------------
  localparam int          TLB_ENTRIES = 4;
  localparam int          ADDRESS_SPACE_ID_W      = 8;

  // ------------------------------------------------------------------
  // Register selection: primary number and opcode_2
  // ------------------------------------------------------------------
  localparam logic [3:0]  CRN_TBASE     = 4'h2;
  localparam logic [3:0]  CRN_DOM       = 4'h3;
  localparam logic [3:0]  CRN_FSTAT     = 4'h5;
  localparam logic [2:0]  OP2_TBASE0    = 3'b000;
  localparam logic [2:0]  OP2_TBASE1    = 3'b001;
  localparam logic [2:0]  OP2_TBCTRL    = 3'b010;
  localparam logic [2:0]  OP2_DOM       = 3'b000;
  localparam logic [2:0]  OP2_DFSTAT    = 3'b000;
  localparam logic [2:0]  OP2_IFSTAT    = 3'b001;

  // ------------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [31:0] TBCTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam logic [31:0] TBCTRL_WMASK  = 32'h0000_0037;
  localparam int          TBCTRL_WDL    = 4;
  localparam int          TBCTRL_WDH    = 5;
  localparam int          FS_SLVERR     = 12;
  localparam int          FS_IMPREC     = 10;
  localparam int          DESC_SEL_BIT  = 19;
  localparam int          DESC_SUPER    = 18;
  localparam int          DESC_NG       = 17;
  localparam int          L2_NG         = 11;

  // ------------------------------------------------------------------
  // Fault status codes, bits 3:0
  // ------------------------------------------------------------------
  localparam logic [3:0]  FS_ALIGN      = 4'b0001;
  localparam logic [3:0]  FS_SECT_XLAT  = 4'b0101;
  localparam logic [3:0]  FS_PAGE_XLAT  = 4'b0111;
  localparam logic [3:0]  FS_L1_EXT     = 4'b1100;
  localparam logic [3:0]  FS_L2_EXT     = 4'b1110;
  localparam logic [3:0]  FS_PREC_EXT   = 4'b1000;
  localparam logic [3:0]  FS_IMPREC_EXT = 4'b0110;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {WTT_IDLE, WTT_L1, WTT_L2} wttlb_state_t;
  typedef enum logic [1:0] {WTT_SZ_SMALL, WTT_SZ_SECT, WTT_SZ_SUPER} wttlb_size_t;

  typedef struct packed {
    logic              valid;
    logic              world_tag;
    logic              global;
    logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
    logic [19:0]       vtag;
    wttlb_size_t       size;
    logic [19:0]       ptag;
    logic              phys_world;
    logic [11:0]       attr;
  } wttlb_entry_t;

endpackage

// ==== rtl/wttlb_top.sv ====
`timescale 1ns/10ps
// Contract
// [R1] Every TLB entry stores the world of the tables it came from; the code tags it with request_world_attr_i instead.
// [R2] Hit needs VA match, ADDRESS_SPACE_ID match or global, and world tag equal current world.
// [R3] A miss walks with the current world's table bases.
// [R4] New entry tag comes from request world attribute; walk result stored.
// [R5] A hit returns stored translation, attributes and physical world.
// [R6] Walk or abort on miss is chosen by table_base_control bits 5:4.
// [R7] walk_disable_low set and first base used: no walk, fault 0b0101.
// [R8] walk_disable_high set and second base used: no walk, section fault.
// [R9] Disable bit clear: walk runs with current world's privilege.
// [R10] Descriptor secure select honoured in Secure world, ignored in Non-secure.
// [R11] Section/supersection: select at bit 19, bit 18 picks supersection.
// [R12] Select bit decoded the same in all first-level formats; the code reads bit 19 of a section and bit 3 of a coarse table descriptor.
// [R13] Banked table bases and control, opcode_2 0b000, 0b001, 0b010.
// [R14] table_base_control resets to zero, both walks enabled.
// [R15] domain_access_ctrl has a Secure and a Non-secure copy.
// [R16] Fault status banked; opcode_2 0b000 data, 0b001 instruction.
// [R17] External abort: status bit 12 is 0 decode error, 1 slave error.
// [R18] Bus should answer decode error or slave error as recommended.
// [R19] Status bit 12 is 0 for all other faults.
// [R20] Walk aborts: first level 0b1100, second level 0b1110, bit 12 kind.
// [R21] Precise abort 0b1000 bit10 clear; imprecise 0b0110 bit10 set; alignment 0b0001.
// [R22] With abort_to_monitor, external aborts write the Secure status copy; the code skips it when a lookup or walk fault is captured that cycle.
// [R23] With abort_to_monitor, every external abort traps to monitor mode.
// [R24] In monitor mode nonsecure_flag picks the banked copy accessed.
// [R25] Otherwise registers and faults use the current world's copies.
// [R26] First-level low bits 00 fault; 11 reserved, also faulted.
module wttlb_top (
  // Clock, reset, enable
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        ce_i,
  // Core state
  input  wire logic                        world_nonsecure_i,
  input  wire logic                        monitor_mode_i,
  input  wire logic                        nonsecure_flag_i,
  input  wire logic                        abort_to_monitor_i,
  input  wire logic [wttlb_pkg::ADDRESS_SPACE_ID_W-1:0] address_space_id_i,
  // Lookup request
  input  wire logic                        lk_valid_i,
  input  wire logic [31:0]                 lk_va_i,
  input  wire logic                        lk_instr_i,
  input  wire logic                        lk_misalign_i,
  input  wire logic                        request_world_attr_i,
  output logic                             lk_ready_o,
  // Lookup answer
  output logic                             rsp_valid_o,
  output logic [31:0]                      rsp_pa_o,
  output logic                             rsp_phys_world_o,
  output logic [11:0]                      rsp_attr_o,
  output logic                             rsp_fault_o,
  // Table walk port
  output logic                             wk_req_o,
  output logic [31:0]                      wk_addr_o,
  output logic                             wk_world_o,
  input  wire logic                        wk_ack_i,
  input  wire logic [31:0]                 wk_data_i,
  input  wire logic                        wk_err_i,
  input  wire logic                        wk_slverr_i,
  // External abort of a core access
  input  wire logic                        ext_abort_i,
  input  wire logic                        ext_instr_i,
  input  wire logic                        ext_precise_i,
  input  wire logic                        ext_slverr_i,
  output logic                             abort_trap_o,
  // Coprocessor register port
  input  wire logic                        cp_wr_i,
  input  wire logic                        cp_rd_i,
  input  wire logic [3:0]                  cp_crn_i,
  input  wire logic [2:0]                  cp_op2_i,
  input  wire logic [31:0]                 cp_wdata_i,
  output logic [31:0]                      cp_rdata_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  // Banked copies are indexed by world: 0 Secure, 1 Non-secure
  typedef struct packed {
    wttlb_pkg::wttlb_state_t                             st;
    logic [1:0][31:0]                                    tbase0;
    logic [1:0][31:0]                                    tbase1;
    logic [1:0][31:0]                                    tb_ctrl;
    logic [1:0][31:0]                                    dom_ctrl;
    logic [1:0][31:0]                                    dfstat;
    logic [1:0][31:0]                                    ifstat;
    wttlb_pkg::wttlb_entry_t [wttlb_pkg::TLB_ENTRIES-1:0] tlb;
    logic [1:0]                                          victim;
    logic [31:0]                                         va;
    logic                                                instr;
    logic                                                req_world;
    logic                                                walk_world;
    logic [wttlb_pkg::ADDRESS_SPACE_ID_W-1:0]                        address_space_id;
    logic [31:0]                                         l1;
    logic                                                wk_req;
    logic [31:0]                                         wk_addr;
    logic                                                rsp_valid;
    logic [31:0]                                         rsp_pa;
    logic                                                rsp_world;
    logic [11:0]                                         rsp_attr;
    logic                                                rsp_fault;
    logic                                                trap;
    logic [31:0]                                         rdata;
  } wttlb_regs_t;

  wttlb_regs_t q;
  wttlb_regs_t d;

  logic                 cur_world;
  logic                 reg_world;
  logic                 hit;
  wttlb_pkg::wttlb_entry_t hit_e;
  logic [19:0]          mask;
  logic                 use_high;
  logic [2:0]           split;
  logic [31:0]          l1_addr;
  logic                 fs_we;
  logic                 fs_instr;
  logic                 fs_bank;
  logic [31:0]          fs_val;
  wttlb_pkg::wttlb_entry_t ne;
  logic [19:0]          rmask;

  function automatic logic [19:0] size_mask(input wttlb_pkg::wttlb_size_t s);
    logic [19:0] m;
    m = 20'hF_FFFF;
    if (s == wttlb_pkg::WTT_SZ_SECT) begin
      m = 20'hF_FF00;
    end else if (s == wttlb_pkg::WTT_SZ_SUPER) begin
      m = 20'hF_F000;
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // World selection and lookup
  // ------------------------------------------------------------------
  // Monitor mode always runs Secure, whatever the core reports
  assign cur_world = world_nonsecure_i & ~monitor_mode_i;
  assign reg_world = monitor_mode_i ? nonsecure_flag_i : cur_world; // [R24] [R25]

  always_comb begin
    hit   = 1'b0;
    hit_e = '0;
    mask  = '0;
    for (int i = 0; i < wttlb_pkg::TLB_ENTRIES; i++) begin
      mask = size_mask(q.tlb[i].size);
      if (q.tlb[i].valid && ((q.tlb[i].vtag ^ lk_va_i[31:12]) & mask) == 20'h0_0000 &&
          (q.tlb[i].global || q.tlb[i].address_space_id == address_space_id_i) &&
          q.tlb[i].world_tag == cur_world) begin // [R2]
        hit   = 1'b1;
        hit_e = q.tlb[i];
      end
    end
  end

  // Second base is used when the top split bits of the address are not all zero
  assign split    = q.tb_ctrl[cur_world][2:0];
  assign use_high = (split != 3'b000) && ((lk_va_i & ~(32'hFFFF_FFFF >> split)) != 32'h0000_0000);
  assign l1_addr  = use_high ?
                    {q.tbase1[cur_world][31:14], lk_va_i[31:20], 2'b00} :
                    ((q.tbase0[cur_world] & (32'hFFFF_FFFF << (5'd14 - {2'b00, split}))) |
                     ({18'h0_0000, lk_va_i[31:20], 2'b00} & (32'h0000_3FFF >> split))); // [R3]

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.trap      = 1'b0;
    fs_we       = 1'b0;
    fs_instr    = 1'b0;
    fs_bank     = cur_world; // [R25]
    fs_val      = 32'h0000_0000;
    ne          = '0;
    rmask       = '0;

    // Register port; fault capture below overrides a write in the same cycle
    if (cp_rd_i) begin
      d.rdata = 32'h0000_0000;
      unique case ({cp_crn_i, cp_op2_i})
        {wttlb_pkg::CRN_TBASE, wttlb_pkg::OP2_TBASE0}: d.rdata = q.tbase0[reg_world];
        {wttlb_pkg::CRN_TBASE, wttlb_pkg::OP2_TBASE1}: d.rdata = q.tbase1[reg_world];
        {wttlb_pkg::CRN_TBASE, wttlb_pkg::OP2_TBCTRL}: d.rdata = q.tb_ctrl[reg_world];
        {wttlb_pkg::CRN_DOM, wttlb_pkg::OP2_DOM}:      d.rdata = q.dom_ctrl[reg_world];
        {wttlb_pkg::CRN_FSTAT, wttlb_pkg::OP2_DFSTAT}: d.rdata = q.dfstat[reg_world];
        {wttlb_pkg::CRN_FSTAT, wttlb_pkg::OP2_IFSTAT}: d.rdata = q.ifstat[reg_world];
        default:                                       d.rdata = 32'h0000_0000;
      endcase
    end
    if (cp_wr_i) begin
      unique case ({cp_crn_i, cp_op2_i})
        {wttlb_pkg::CRN_TBASE, wttlb_pkg::OP2_TBASE0}: d.tbase0[reg_world] = cp_wdata_i; // [R13]
        {wttlb_pkg::CRN_TBASE, wttlb_pkg::OP2_TBASE1}: d.tbase1[reg_world] = cp_wdata_i; // [R13]
        {wttlb_pkg::CRN_TBASE, wttlb_pkg::OP2_TBCTRL}:
          d.tb_ctrl[reg_world] = cp_wdata_i & wttlb_pkg::TBCTRL_WMASK; // [R13]
        {wttlb_pkg::CRN_DOM, wttlb_pkg::OP2_DOM}:      d.dom_ctrl[reg_world] = cp_wdata_i; // [R15]
        {wttlb_pkg::CRN_FSTAT, wttlb_pkg::OP2_DFSTAT}: d.dfstat[reg_world] = cp_wdata_i; // [R16]
        {wttlb_pkg::CRN_FSTAT, wttlb_pkg::OP2_IFSTAT}: d.ifstat[reg_world] = cp_wdata_i; // [R16]
        default: ;
      endcase
    end

    // External abort of an ordinary access
    if (ext_abort_i) begin
      fs_we    = 1'b1;
      fs_instr = ext_instr_i;
      fs_val[wttlb_pkg::FS_SLVERR] = ext_slverr_i; // [R17]
      if (ext_precise_i) begin
        fs_val[3:0] = wttlb_pkg::FS_PREC_EXT; // [R21]
      end else begin
        fs_val[3:0] = wttlb_pkg::FS_IMPREC_EXT; // [R21]
        fs_val[wttlb_pkg::FS_IMPREC] = 1'b1;
      end
      if (abort_to_monitor_i) begin
        d.trap  = 1'b1; // [R23]
        fs_bank = 1'b0; // [R22]
      end
    end

    unique case (q.st)
      wttlb_pkg::WTT_IDLE: begin
        if (lk_valid_i) begin
          d.va        = lk_va_i;
          d.instr     = lk_instr_i;
          d.req_world = request_world_attr_i;
          d.walk_world = cur_world;
          d.address_space_id      = address_space_id_i;
          if (lk_misalign_i) begin
            d.rsp_valid = 1'b1;
            d.rsp_fault = 1'b1;
            fs_we       = 1'b1;
            fs_instr    = lk_instr_i;
            fs_bank     = cur_world;
            fs_val      = {28'h000_0000, wttlb_pkg::FS_ALIGN}; // [R21] [R19]
          end else if (hit) begin
            rmask         = size_mask(hit_e.size);
            d.rsp_valid   = 1'b1;
            d.rsp_fault   = 1'b0;
            d.rsp_pa      = {(hit_e.ptag & rmask) | (lk_va_i[31:12] & ~rmask),
                             lk_va_i[11:0]}; // [R5]
            d.rsp_world   = hit_e.phys_world; // [R5]
            d.rsp_attr    = hit_e.attr; // [R5]
          end else if ((use_high && q.tb_ctrl[cur_world][wttlb_pkg::TBCTRL_WDH]) || // [R6] [R8]
                       (!use_high && q.tb_ctrl[cur_world][wttlb_pkg::TBCTRL_WDL])) begin // [R7]
            d.rsp_valid = 1'b1;
            d.rsp_fault = 1'b1;
            fs_we       = 1'b1;
            fs_instr    = lk_instr_i;
            fs_bank     = cur_world;
            fs_val      = {28'h000_0000, wttlb_pkg::FS_SECT_XLAT}; // [R7] [R8] [R19]
          end else begin
            d.wk_req  = 1'b1; // [R9]
            d.wk_addr = l1_addr; // [R3]
            d.st      = wttlb_pkg::WTT_L1;
          end
        end
      end
      wttlb_pkg::WTT_L1: begin
        if (wk_ack_i) begin
          d.wk_req = 1'b0;
          d.l1     = wk_data_i;
          ne.valid      = 1'b1;
          ne.world_tag  = q.req_world; // [R1] [R4]
          ne.address_space_id       = q.address_space_id;
          ne.vtag       = q.va[31:12];
          ne.global     = ~wk_data_i[wttlb_pkg::DESC_NG];
          ne.attr       = wk_data_i[11:0];
          ne.phys_world = q.walk_world | wk_data_i[wttlb_pkg::DESC_SEL_BIT]; // [R10] [R11] [R12]
          if (wk_data_i[wttlb_pkg::DESC_SUPER]) begin
            ne.size = wttlb_pkg::WTT_SZ_SUPER; // [R11]
            ne.ptag = {wk_data_i[31:24], 12'h000};
          end else begin
            ne.size = wttlb_pkg::WTT_SZ_SECT; // [R11]
            ne.ptag = {wk_data_i[31:20], 8'h00};
          end
          d.st = wttlb_pkg::WTT_IDLE;
          if (wk_err_i) begin
            fs_we    = 1'b1;
            fs_bank  = q.walk_world;
            fs_val   = {19'h0_0000, wk_slverr_i, 8'h00, wttlb_pkg::FS_L1_EXT}; // [R20] [R17]
            if (abort_to_monitor_i) begin
              d.trap  = 1'b1; // [R23]
              fs_bank = 1'b0; // [R22]
            end
          end else if (wk_data_i[1:0] == 2'b01) begin
            // Coarse table: fetch the second-level descriptor
            d.wk_req  = 1'b1;
            d.wk_addr = {wk_data_i[31:10], q.va[19:12], 2'b00};
            d.st      = wttlb_pkg::WTT_L2;
          end else if (wk_data_i[1:0] == 2'b10) begin
            d.tlb[q.victim] = ne; // [R4]
            d.victim        = q.victim + 2'd1;
          end else begin
            fs_we   = 1'b1;
            fs_bank = q.walk_world;
            fs_val  = {28'h000_0000, wttlb_pkg::FS_SECT_XLAT}; // [R26] [R19]
          end
          fs_instr    = q.instr;
          d.rsp_valid = (d.st == wttlb_pkg::WTT_IDLE);
          d.rsp_fault = fs_we;
          rmask       = size_mask(ne.size);
          d.rsp_pa    = {(ne.ptag & rmask) | (q.va[31:12] & ~rmask), q.va[11:0]};
          d.rsp_world = ne.phys_world;
          d.rsp_attr  = ne.attr;
        end
      end
      wttlb_pkg::WTT_L2: begin
        if (wk_ack_i) begin
          d.wk_req      = 1'b0;
          d.st          = wttlb_pkg::WTT_IDLE;
          ne.valid      = 1'b1;
          ne.world_tag  = q.req_world; // [R1] [R4]
          ne.address_space_id       = q.address_space_id;
          ne.vtag       = q.va[31:12];
          ne.size       = wttlb_pkg::WTT_SZ_SMALL;
          ne.ptag       = wk_data_i[31:12];
          ne.global     = ~wk_data_i[wttlb_pkg::L2_NG];
          ne.attr       = wk_data_i[11:0];
          // Coarse descriptors keep their select bit at bit 3
          ne.phys_world = q.walk_world | q.l1[3]; // [R10] [R12]
          fs_instr      = q.instr;
          if (wk_err_i) begin
            fs_we    = 1'b1;
            fs_bank  = q.walk_world;
            fs_val   = {19'h0_0000, wk_slverr_i, 8'h00, wttlb_pkg::FS_L2_EXT}; // [R20] [R17]
            if (abort_to_monitor_i) begin
              d.trap  = 1'b1; // [R23]
              fs_bank = 1'b0; // [R22]
            end
          end else if (wk_data_i[1:0] == 2'b00) begin
            fs_we  = 1'b1;
            fs_bank = q.walk_world;
            fs_val = {28'h000_0000, wttlb_pkg::FS_PAGE_XLAT}; // [R19]
          end else begin
            d.tlb[q.victim] = ne; // [R4]
            d.victim        = q.victim + 2'd1;
          end
          d.rsp_valid = 1'b1;
          d.rsp_fault = fs_we;
          d.rsp_pa    = {ne.ptag, q.va[11:0]};
          d.rsp_world = ne.phys_world;
          d.rsp_attr  = ne.attr;
        end
      end
      default: d.st = wttlb_pkg::WTT_IDLE;
    endcase

    // Fault capture wins over a software write in the same cycle
    if (fs_we) begin
      if (fs_instr) begin
        d.ifstat[fs_bank] = fs_val; // [R16]
      end else begin
        d.dfstat[fs_bank] = fs_val; // [R16]
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // All-zero reset: idle, empty TLB, control copies at their zero reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0; // [R14]
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign lk_ready_o       = (q.st == wttlb_pkg::WTT_IDLE);
  assign rsp_valid_o      = q.rsp_valid;
  assign rsp_pa_o         = q.rsp_pa;
  assign rsp_phys_world_o = q.rsp_world;
  assign rsp_attr_o       = q.rsp_attr;
  assign rsp_fault_o      = q.rsp_fault;
  assign wk_req_o         = q.wk_req;
  assign wk_addr_o        = q.wk_addr;
  assign wk_world_o       = q.walk_world; // [R9]
  assign abort_trap_o     = q.trap;
  assign cp_rdata_o       = q.rdata;

endmodule

// ==== sim/wttlb_top_properties.sv ====
`timescale 1ns/10ps
module wttlb_top_properties (
  input wire logic        ref_clk_i, rst_n_i, world_nonsecure_i, monitor_mode_i,
  input wire logic        lk_valid_i, lk_ready_o, rsp_valid_o, rsp_fault_o, wk_req_o,
  input wire logic        wk_world_o, wk_ack_i, wk_err_i, ext_abort_i, abort_to_monitor_i,
  input wire logic        abort_trap_o,
  input wire logic [31:0] wk_addr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_walk_world: assert property ($rose(wk_req_o) |->
    wk_world_o == ($past(world_nonsecure_i) && !$past(monitor_mode_i))) else $error("walk world");
  chk_walk_hold: assert property (wk_req_o && !wk_ack_i |=>
    wk_req_o && $stable(wk_addr_o)) else $error("walk request moved");
  chk_busy_refuse: assert property (wk_req_o |-> !lk_ready_o)
    else $error("ready while walking");
  chk_miss_action: assert property (lk_valid_i && lk_ready_o |=>
    rsp_valid_o || wk_req_o) else $error("lookup ignored");
  chk_walk_bound: assert property ($rose(wk_req_o) |-> ##[1:40] rsp_valid_o)
    else $error("walk unanswered");
  chk_err_fault: assert property (wk_req_o && wk_ack_i && wk_err_i |=>
    rsp_valid_o && rsp_fault_o && !wk_req_o) else $error("walk abort lost");
  chk_trap_set: assert property (ext_abort_i && abort_to_monitor_i |=> abort_trap_o)
    else $error("abort not trapped");
  chk_trap_clear: assert property (!(ext_abort_i && abort_to_monitor_i) |=> !abort_trap_o)
    else $error("spurious trap");
  cover property (wk_req_o && wk_ack_i && wk_err_i);
  cover property (abort_trap_o);
  cover property (rsp_valid_o && !rsp_fault_o);
endmodule

// ==== sim/wttlb_walk_mem.sv ====
`timescale 1ns/10ps
module wttlb_walk_mem (
  input  wire logic        ref_clk_i, rst_n_i, req_i, err_cfg_i, slv_cfg_i,
  input  wire logic [1:0]  dly_i,
  input  wire logic [31:0] desc_i,
  output logic             ack_o, err_o, slv_o,
  output logic [31:0]      data_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {ack_o, err_o, slv_o, data_o, cnt_q} <= '0;
    end else if (ack_o) begin
      // Released data inverts, so a stale descriptor never looks fresh
      {ack_o, err_o, slv_o, data_o, cnt_q} <= {3'b000, ~data_o, 2'd0};
    end else if (req_i && cnt_q == dly_i) begin
      {ack_o, err_o, slv_o, data_o} <= {1'b1, err_cfg_i, err_cfg_i & slv_cfg_i, desc_i};
    end else if (req_i) begin
      cnt_q <= cnt_q + 2'd1;
    end
  end
endmodule

// ==== sim/world_tagged_tlb_walk_fault_test.sv ====
`timescale 1ns/10ps
module world_tagged_tlb_walk_fault_test;
  logic ref_clk_i = 0, rst_n_i = 0, ce_i = 1, world_nonsecure_i = 0, monitor_mode_i = 0;
  logic nonsecure_flag_i = 0, abort_to_monitor_i = 0, lk_valid_i = 0, lk_instr_i = 0;
  logic lk_misalign_i = 0, request_world_attr_i = 0, ext_abort_i = 0, ext_instr_i = 0;
  logic ext_precise_i = 0, ext_slverr_i = 0, cp_wr_i = 0, cp_rd_i = 0, err_cfg = 0, slv_cfg = 0;
  logic lk_ready_o, rsp_valid_o, rsp_phys_world_o, rsp_fault_o, wk_req_o, wk_world_o, walked;
  logic abort_trap_o, wk_ack_i, wk_err_i, wk_slverr_i;
  logic [1:0]  dly = 0;
  logic [3:0]  cp_crn_i = 0;
  logic [2:0]  cp_op2_i = 0;
  logic [11:0] rsp_attr_o;
  logic [31:0] lk_va_i = 0, cp_wdata_i = 0, desc = 0, rsp_pa_o, wk_addr_o, wk_data_i;
  logic [31:0] cp_rdata_o, wk_seen;
  logic [wttlb_pkg::ADDRESS_SPACE_ID_W-1:0] address_space_id_i = 0;
  int miscompares = 0, samples_checked = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  wttlb_top uut (.ref_clk_i, .rst_n_i, .ce_i, .world_nonsecure_i, .monitor_mode_i,
    .nonsecure_flag_i, .abort_to_monitor_i, .address_space_id_i, .lk_valid_i, .lk_va_i,
    .lk_instr_i, .lk_misalign_i, .request_world_attr_i, .lk_ready_o, .rsp_valid_o, .rsp_pa_o,
    .rsp_phys_world_o, .rsp_attr_o, .rsp_fault_o, .wk_req_o, .wk_addr_o, .wk_world_o,
    .wk_ack_i, .wk_data_i, .wk_err_i, .wk_slverr_i, .ext_abort_i, .ext_instr_i,
    .ext_precise_i, .ext_slverr_i, .abort_trap_o, .cp_wr_i, .cp_rd_i, .cp_crn_i, .cp_op2_i,
    .cp_wdata_i, .cp_rdata_o);
  wttlb_walk_mem mem (.ref_clk_i, .rst_n_i, .req_i(wk_req_o), .err_cfg_i(err_cfg),
    .slv_cfg_i(slv_cfg), .dly_i(dly), .desc_i(desc), .ack_o(wk_ack_i), .err_o(wk_err_i),
    .slv_o(wk_slverr_i), .data_o(wk_data_i));
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic st(logic ns, logic mon, logic flag);
    @(negedge ref_clk_i);
    {world_nonsecure_i, monitor_mode_i, nonsecure_flag_i} = {ns, mon, flag};
  endtask
  task automatic cp(logic wr, logic [3:0] crn, logic [2:0] op2, logic [31:0] d);
    @(negedge ref_clk_i);
    {cp_wr_i, cp_rd_i, cp_crn_i, cp_op2_i, cp_wdata_i} = {wr, !wr, crn, op2, d};
    @(negedge ref_clk_i);
    {cp_wr_i, cp_rd_i} = 2'b00;
  endtask
  task automatic rd(string n, logic [3:0] crn, logic [2:0] op2, logic [31:0] exp);
    cp(0, crn, op2, 0);
    chk(n, cp_rdata_o, exp);
  endtask
  task automatic abt(logic ins, logic pre, logic slv);
    @(negedge ref_clk_i);
    {ext_abort_i, ext_instr_i, ext_precise_i, ext_slverr_i} = {1'b1, ins, pre, slv};
    @(negedge ref_clk_i);
    ext_abort_i = 0;
  endtask
  task automatic look(logic [31:0] va);
    @(negedge ref_clk_i);
    {lk_va_i, lk_valid_i, walked} = {va, 2'b10};
    @(negedge ref_clk_i);
    lk_valid_i = 0;
    for (int i = 0; i < 40 && rsp_valid_o !== 1; i++) begin
      if (wk_req_o && !walked) {walked, wk_seen} = {1'b1, wk_addr_o};
      @(negedge ref_clk_i);
    end
    if (rsp_valid_o !== 1) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic t_regs();
    rd("ctrl", 4'h2, 3'h2, 0);
    cp(1, 4'h2, 3'h0, 32'h0000_4000);
    cp(1, 4'h3, 3'h0, 32'h0000_0055);
    st(0, 1, 1);
    cp(1, 4'h2, 3'h0, 32'h0000_8000);
    rd("dom_ns", 4'h3, 3'h0, 0);
    rd("unmapped", 4'h4, 3'h0, 0);
    st(1, 0, 0);
    rd("base_ns", 4'h2, 3'h0, 32'h0000_8000);
    st(0, 1, 0);
    rd("base_s", 4'h2, 3'h0, 32'h0000_4000);
  endtask
  // Split field stays 0, so only the first table base is ever used
  task automatic t_walk();
    st(0, 0, 0);
    {desc, dly} = {32'h8008_0C02, 2'd2};
    look(32'h0010_0123);
    chk("l1_addr", wk_seen, 32'h0000_4004);
    chk("pa", rsp_pa_o, 32'h8000_0123);
    chk("attr", rsp_attr_o, 32'h0000_0C02);
    chk("phys_sel", rsp_phys_world_o, 1);
    look(32'h0010_0456);
    chk("hit", walked, 0);
    request_world_attr_i = 1;
    look(32'h0020_0000);
    look(32'h0020_0000);
    chk("tag_miss", walked, 1);
    st(1, 0, 0);
    {desc, dly} = {32'h9000_0C02, 2'd0};
    look(32'h0020_0000);
    chk("tag_hit", walked, 0);
    look(32'h0030_0000);
    chk("l1_addr_ns", wk_seen, 32'h0000_800C);
    chk("phys_ns", rsp_phys_world_o, 1);
    desc = 32'h7000_0001;
    look(32'h00A0_0345);
    chk("l2_pa", rsp_pa_o, 32'h7000_0345);
  endtask
  task automatic t_fault();
    st(1, 1, 1);
    cp(1, 4'h2, 3'h2, 32'h0000_0010);
    st(1, 0, 0);
    look(32'h0300_0000);
    chk("no_walk", walked, 0);
    rd("data_fault_status_ns", 4'h5, 3'h0, 32'h0000_0005);
    st(0, 0, 0);
    {request_world_attr_i, err_cfg, slv_cfg, dly} = {3'b011, 2'd3};
    look(32'h0400_0000);
    chk("walk_on", walked, 1);
    rd("l1_slverr", 4'h5, 3'h0, 32'h0000_100C);
    {slv_cfg, lk_instr_i} = 2'b01;
    look(32'h0500_0000);
    rd("l1_decerr", 4'h5, 3'h1, 32'h0000_000C);
    {err_cfg, lk_instr_i} = 2'b00;
    for (int k = 0; k < 4; k += 3) begin
      desc = k;
      look(32'h0600_0000);
      rd("desc_bad", 4'h5, 3'h0, 32'h0000_0005);
    end
    lk_misalign_i = 1;
    look(32'h0010_0000);
    lk_misalign_i = 0;
    rd("align", 4'h5, 3'h0, 32'h0000_0001);
  endtask
  task automatic t_abort();
    abort_to_monitor_i = 1;
    st(1, 0, 0);
    abt(0, 1, 1);
    chk("trap", abort_trap_o, 1);
    abt(1, 0, 0);
    st(1, 1, 0);
    rd("data_fault_status_s", 4'h5, 3'h0, 32'h0000_1008);
    rd("instr_fault_status_s", 4'h5, 3'h1, 32'h0000_0406);
    abort_to_monitor_i = 0;
    st(1, 0, 0);
    abt(0, 1, 0);
    chk("no_trap", abort_trap_o, 0);
    rd("data_fault_status_ns2", 4'h5, 3'h0, 32'h0000_0008);
  endtask
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1;
    t_regs();
    t_walk();
    t_fault();
    t_abort();
    end_sim();
  end
endmodule
bind wttlb_top wttlb_top_properties chk_i (.ref_clk_i, .rst_n_i, .world_nonsecure_i,
  .monitor_mode_i, .lk_valid_i, .lk_ready_o, .rsp_valid_o, .rsp_fault_o, .wk_req_o,
  .wk_world_o, .wk_ack_i, .wk_err_i, .ext_abort_i, .abort_to_monitor_i, .abort_trap_o,
  .wk_addr_o);
